//--- shared/btg_pkg.sv
// Contract
// (RL1) Writing one to the enable bit starts the tone, and the block clears it after the programmed count.
// (RL2) While the enable bit is zero the tone outputs carry only zero samples.
// (RL3) The six-bit left gain code gives +2 dB at zero and one dB less per step, down to -61 dB.
// (RL4) The six-bit right gain code uses the same encoding as the left one.
// (RL5) With link code 00 or 11 each channel uses its own gain code.
// (RL6) With link code 01 the left channel also uses the right gain code.
// (RL7) With link code 10 the right channel also uses the left gain code.
// (RL8) The duration is a 24-bit sample count from three byte registers, reset to 238.
// (RL9) The sine coefficient is a 16-bit value in two byte registers, reset to 0x10d8.
// (RL10) The cosine coefficient is a 16-bit value in two byte registers, reset to 0x7ee3.
// (RL11) The oscillator only advances while the datapath is in tone processing mode.
// (RL12) Software writes only zero into the reserved bit of the left control register.
// (RL13) The sine is made by a fixed-point rotation, one sample per word clock, counting down the duration.
// (RL14) Every start resets the oscillator and the duration counter to their initial values.
package btg_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [6:0] BTG_ADDR_LEFT = 7'h47;
	localparam logic [6:0] BTG_ADDR_RIGHT = 7'h48;
	localparam logic [6:0] BTG_ADDR_LEN_HI = 7'h49;
	localparam logic [6:0] BTG_ADDR_LEN_MID = 7'h4a;
	localparam logic [6:0] BTG_ADDR_LEN_LO = 7'h4b;
	localparam logic [6:0] BTG_ADDR_SIN_HI = 7'h4c;
	localparam logic [6:0] BTG_ADDR_SIN_LO = 7'h4d;
	localparam logic [6:0] BTG_ADDR_COS_HI = 7'h4e;
	localparam logic [6:0] BTG_ADDR_COS_LO = 7'h4f;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BTG_EN_BIT = 7;
	localparam int BTG_RSVD_BIT = 6;
	localparam int BTG_GAIN_MSB = 5;
	localparam int BTG_LINK_MSB = 7;
	localparam int BTG_LINK_LSB = 6;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] BTG_RST_LEFT = 8'h00;
	localparam logic [7:0] BTG_RST_RIGHT = 8'h00;
	localparam logic [7:0] BTG_RST_LEN_HI = 8'h00;
	localparam logic [7:0] BTG_RST_LEN_MID = 8'h00;
	localparam logic [7:0] BTG_RST_LEN_LO = 8'hee;
	localparam logic [7:0] BTG_RST_SIN_HI = 8'h10;
	localparam logic [7:0] BTG_RST_SIN_LO = 8'hd8;
	localparam logic [7:0] BTG_RST_COS_HI = 8'h7e;
	localparam logic [7:0] BTG_RST_COS_LO = 8'he3;

	// ****************************************
	// Volume link codes
	// ****************************************
	localparam logic [1:0] BTG_LINK_OWN = 2'h0;
	localparam logic [1:0] BTG_LINK_RIGHT = 2'h1;
	localparam logic [1:0] BTG_LINK_LEFT = 2'h2;
	localparam logic [1:0] BTG_LINK_SAME = 2'h3;

	// ****************************************
	// Arithmetic
	// ****************************************
	localparam int BTG_OSC_FRAC = 15;
	localparam int BTG_GAIN_FRAC = 14;
	localparam logic [5:0] BTG_STEPS_PER_HALVING = 6'h06;
	localparam logic signed [15:0] BTG_OSC_INIT_X = 16'sh7fff;
	localparam logic signed [15:0] BTG_OSC_INIT_Y = 16'sh0000;
	// Gains of +2, +1, 0, -1, -2, -3 dB in Q2.14
	localparam logic [15:0] BTG_MANT [0:5] = '{16'h5092, 16'h47cf, 16'h4000,
		16'h390b, 16'h32d6, 16'h2d4f};

	typedef enum logic {BTG_IDLE, BTG_RUN} btg_state_type;

	function automatic logic signed [15:0] btg_sat16(input logic signed [33:0] v);
		logic signed [15:0] r;
		r = v[15:0];
		if (v > 34'sd32767)
		begin
			r = 16'sh7fff;
		end
		else if (v < -34'sd32768)
		begin
			r = 16'sh8000;
		end
		return r;
	endfunction

endpackage

//--- shared/btg_gain_if.sv
interface btg_gain_if;
	logic in_valid;
	logic signed [15:0] in_sample;
	logic [5:0] code;
	logic out_valid;
	logic signed [15:0] out_sample;

	modport src
	(
		output in_valid,
		output in_sample,
		output code,
		input out_valid,
		input out_sample
	);

	modport scale
	(
		input in_valid,
		input in_sample,
		input code,
		output out_valid,
		output out_sample
	);
endinterface

//--- core/btg_gain.sv
module btg_gain
(
	input wire logic core_clk,
	input wire logic rst_n,
	btg_gain_if.scale gi
);

	logic [5:0] halvings;
	logic [5:0] step;
	logic [15:0] mant;
	logic signed [33:0] prod;
	logic signed [33:0] scaled;
	logic signed [15:0] next_out_sample;
	logic next_out_valid;

	// ****************************************
	// Gain from code
	// ****************************************
	always_comb
	begin
		halvings = gi.code / btg_pkg::BTG_STEPS_PER_HALVING;
		step = gi.code % btg_pkg::BTG_STEPS_PER_HALVING;
		mant = btg_pkg::BTG_MANT[step[2:0]];
		prod = $signed({{18{gi.in_sample[15]}}, gi.in_sample}) * $signed({18'h00000, mant}); // RL3 RL4
		scaled = prod >>> (btg_pkg::BTG_GAIN_FRAC + int'(halvings));
		next_out_sample = gi.out_sample;
		if (gi.in_valid)
		begin
			next_out_sample = btg_pkg::btg_sat16(scaled);
		end
		next_out_valid = gi.in_valid;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gi.out_valid <= 1'b0;
			gi.out_sample <= 16'sh0000;
		end
		else
		begin
			gi.out_valid <= next_out_valid;
			gi.out_sample <= next_out_sample;
		end
	end

	property p_unity;
		@(posedge core_clk) disable iff (!rst_n)
		gi.in_valid && gi.code == 6'h02 |=> gi.out_sample == $past(gi.in_sample);
	endproperty
	a_unity: assert property (p_unity) else $error("Unity code does not pass the sample"); // RL3

	property p_half;
		@(posedge core_clk) disable iff (!rst_n)
		gi.in_valid && gi.code == 6'h08 |=> gi.out_sample == ($past(gi.in_sample) >>> 1);
	endproperty
	a_half: assert property (p_half) else $error("Six dB step does not halve"); // RL4

endmodule

//--- core/btg_top.sv
module btg_top
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic sample_tick,
	input wire logic tone_processing_mode,
	input wire logic reg_wr,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic signed [15:0] tone_left,
	output logic signed [15:0] tone_right,
	output logic tone_valid,
	output logic tone_active
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [5:0] gain_l;
	logic rsvd_l;
	logic [1:0] link;
	logic [5:0] gain_r;
	logic [7:0] len_hi;
	logic [7:0] len_mid;
	logic [7:0] len_lo;
	logic [7:0] sin_hi;
	logic [7:0] sin_lo;
	logic [7:0] cos_hi;
	logic [7:0] cos_lo;
	logic [5:0] next_gain_l;
	logic next_rsvd_l;
	logic [1:0] next_link;
	logic [5:0] next_gain_r;
	logic [7:0] next_len_hi;
	logic [7:0] next_len_mid;
	logic [7:0] next_len_lo;
	logic [7:0] next_sin_hi;
	logic [7:0] next_sin_lo;
	logic [7:0] next_cos_hi;
	logic [7:0] next_cos_lo;
	logic [23:0] len_cfg;
	logic signed [15:0] sin_coef;
	logic signed [15:0] cos_coef;

	assign len_cfg = {len_hi, len_mid, len_lo}; // RL8
	assign sin_coef = {sin_hi, sin_lo}; // RL9
	assign cos_coef = {cos_hi, cos_lo}; // RL10

	always_comb
	begin
		next_gain_l = gain_l;
		next_rsvd_l = rsvd_l;
		next_link = link;
		next_gain_r = gain_r;
		next_len_hi = len_hi;
		next_len_mid = len_mid;
		next_len_lo = len_lo;
		next_sin_hi = sin_hi;
		next_sin_lo = sin_lo;
		next_cos_hi = cos_hi;
		next_cos_lo = cos_lo;
		if (reg_wr)
		begin
			unique case (reg_addr)
				btg_pkg::BTG_ADDR_LEFT:
				begin
					next_gain_l = reg_wdata[btg_pkg::BTG_GAIN_MSB:0];
					next_rsvd_l = reg_wdata[btg_pkg::BTG_RSVD_BIT];
				end
				btg_pkg::BTG_ADDR_RIGHT:
				begin
					next_link = reg_wdata[btg_pkg::BTG_LINK_MSB:btg_pkg::BTG_LINK_LSB];
					next_gain_r = reg_wdata[btg_pkg::BTG_GAIN_MSB:0];
				end
				btg_pkg::BTG_ADDR_LEN_HI: next_len_hi = reg_wdata;
				btg_pkg::BTG_ADDR_LEN_MID: next_len_mid = reg_wdata;
				btg_pkg::BTG_ADDR_LEN_LO: next_len_lo = reg_wdata;
				btg_pkg::BTG_ADDR_SIN_HI: next_sin_hi = reg_wdata;
				btg_pkg::BTG_ADDR_SIN_LO: next_sin_lo = reg_wdata;
				btg_pkg::BTG_ADDR_COS_HI: next_cos_hi = reg_wdata;
				btg_pkg::BTG_ADDR_COS_LO: next_cos_lo = reg_wdata;
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gain_l <= btg_pkg::BTG_RST_LEFT[btg_pkg::BTG_GAIN_MSB:0];
			rsvd_l <= btg_pkg::BTG_RST_LEFT[btg_pkg::BTG_RSVD_BIT];
			link <= btg_pkg::BTG_RST_RIGHT[btg_pkg::BTG_LINK_MSB:btg_pkg::BTG_LINK_LSB];
			gain_r <= btg_pkg::BTG_RST_RIGHT[btg_pkg::BTG_GAIN_MSB:0];
			len_hi <= btg_pkg::BTG_RST_LEN_HI;
			len_mid <= btg_pkg::BTG_RST_LEN_MID;
			len_lo <= btg_pkg::BTG_RST_LEN_LO;
			sin_hi <= btg_pkg::BTG_RST_SIN_HI;
			sin_lo <= btg_pkg::BTG_RST_SIN_LO;
			cos_hi <= btg_pkg::BTG_RST_COS_HI;
			cos_lo <= btg_pkg::BTG_RST_COS_LO;
		end
		else
		begin
			gain_l <= next_gain_l;
			rsvd_l <= next_rsvd_l;
			link <= next_link;
			gain_r <= next_gain_r;
			len_hi <= next_len_hi;
			len_mid <= next_len_mid;
			len_lo <= next_len_lo;
			sin_hi <= next_sin_hi;
			sin_lo <= next_sin_lo;
			cos_hi <= next_cos_hi;
			cos_lo <= next_cos_lo;
		end
	end

	// ****************************************
	// Sequencer and oscillator
	// ****************************************
	btg_pkg::btg_state_type state;
	btg_pkg::btg_state_type next_state;
	logic [23:0] remaining;
	logic [23:0] next_remaining;
	logic signed [15:0] osc_x;
	logic signed [15:0] osc_y;
	logic signed [15:0] next_osc_x;
	logic signed [15:0] next_osc_y;
	logic raw_valid;
	logic next_raw_valid;
	logic signed [15:0] raw_sample [2];
	logic signed [15:0] next_raw_sample [2];
	logic wr_left;
	logic start;
	logic stop;
	logic step;
	logic signed [31:0] p_cx;
	logic signed [31:0] p_sy;
	logic signed [31:0] p_sx;
	logic signed [31:0] p_cy;
	logic signed [33:0] rot_x;
	logic signed [33:0] rot_y;

	assign wr_left = reg_wr && reg_addr == btg_pkg::BTG_ADDR_LEFT;
	assign start = wr_left && reg_wdata[btg_pkg::BTG_EN_BIT];
	assign stop = wr_left && !reg_wdata[btg_pkg::BTG_EN_BIT];
	assign step = sample_tick && tone_processing_mode && state == btg_pkg::BTG_RUN; // RL11

	always_comb
	begin
		p_cx = cos_coef * osc_x;
		p_sy = sin_coef * osc_y;
		p_sx = sin_coef * osc_x;
		p_cy = cos_coef * osc_y;
		rot_x = (34'(p_cx) - 34'(p_sy)) >>> btg_pkg::BTG_OSC_FRAC; // RL13
		rot_y = (34'(p_sx) + 34'(p_cy)) >>> btg_pkg::BTG_OSC_FRAC; // RL13
		next_state = state;
		next_remaining = remaining;
		next_osc_x = osc_x;
		next_osc_y = osc_y;
		next_raw_valid = sample_tick;
		next_raw_sample[0] = 16'sh0000; // RL2
		next_raw_sample[1] = 16'sh0000; // RL2
		if (step)
		begin
			next_raw_sample[0] = osc_y;
			next_raw_sample[1] = osc_y;
			next_osc_x = btg_pkg::btg_sat16(rot_x);
			next_osc_y = btg_pkg::btg_sat16(rot_y);
			next_remaining = remaining - 24'h000001; // RL13
			if (remaining == 24'h000001)
			begin
				next_state = btg_pkg::BTG_IDLE; // RL1
			end
		end
		// Software start wins over the self clear
		if (start)
		begin
			next_osc_x = btg_pkg::BTG_OSC_INIT_X; // RL14
			next_osc_y = btg_pkg::BTG_OSC_INIT_Y; // RL14
			next_remaining = len_cfg; // RL14
			next_state = (len_cfg != 24'h000000) ? btg_pkg::BTG_RUN : btg_pkg::BTG_IDLE; // RL1
		end
		else if (stop)
		begin
			next_state = btg_pkg::BTG_IDLE;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= btg_pkg::BTG_IDLE;
			remaining <= 24'h000000;
			osc_x <= btg_pkg::BTG_OSC_INIT_X;
			osc_y <= btg_pkg::BTG_OSC_INIT_Y;
			raw_valid <= 1'b0;
			raw_sample[0] <= 16'sh0000;
			raw_sample[1] <= 16'sh0000;
		end
		else
		begin
			state <= next_state;
			remaining <= next_remaining;
			osc_x <= next_osc_x;
			osc_y <= next_osc_y;
			raw_valid <= next_raw_valid;
			raw_sample[0] <= next_raw_sample[0];
			raw_sample[1] <= next_raw_sample[1];
		end
	end

	assign tone_active = state == btg_pkg::BTG_RUN;

	// ****************************************
	// Channel gain
	// ****************************************
	logic [5:0] chan_code [2];

	assign chan_code[0] = (link == btg_pkg::BTG_LINK_RIGHT) ? gain_r : gain_l; // RL5 RL6
	assign chan_code[1] = (link == btg_pkg::BTG_LINK_LEFT) ? gain_l : gain_r; // RL5 RL7

	logic signed [15:0] chan_out [2];
	logic chan_valid [2];

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		btg_gain_if gif ();
		assign gif.in_valid = raw_valid;
		assign gif.in_sample = raw_sample[ch];
		assign gif.code = chan_code[ch];
		assign chan_out[ch] = gif.out_sample;
		assign chan_valid[ch] = gif.out_valid;
		btg_gain u_gain
		(
			.core_clk(core_clk),
			.rst_n(rst_n),
			.gi(gif)
		);
	end

	assign tone_left = chan_out[0];
	assign tone_right = chan_out[1];
	assign tone_valid = chan_valid[0];

	// ****************************************
	// Read back
	// ****************************************
	logic [7:0] next_reg_rdata;

	always_comb
	begin
		unique case (reg_addr)
			btg_pkg::BTG_ADDR_LEFT: next_reg_rdata = {tone_active, rsvd_l, gain_l}; // RL1
			btg_pkg::BTG_ADDR_RIGHT: next_reg_rdata = {link, gain_r};
			btg_pkg::BTG_ADDR_LEN_HI: next_reg_rdata = len_hi;
			btg_pkg::BTG_ADDR_LEN_MID: next_reg_rdata = len_mid;
			btg_pkg::BTG_ADDR_LEN_LO: next_reg_rdata = len_lo;
			btg_pkg::BTG_ADDR_SIN_HI: next_reg_rdata = sin_hi;
			btg_pkg::BTG_ADDR_SIN_LO: next_reg_rdata = sin_lo;
			btg_pkg::BTG_ADDR_COS_HI: next_reg_rdata = cos_hi;
			btg_pkg::BTG_ADDR_COS_LO: next_reg_rdata = cos_lo;
			default: next_reg_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata <= 8'h00;
		end
		else
		begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_start;
		@(posedge core_clk) disable iff (!rst_n)
		start && len_cfg != 24'h000000 |=> tone_active && remaining == $past(len_cfg)
			&& osc_y == 16'sh0000 && osc_x == 16'sh7fff;
	endproperty
	a_start: assert property (p_start) else $error("Start did not load the generator"); // RL14

	property p_self_clear;
		@(posedge core_clk) disable iff (!rst_n)
		step && remaining == 24'h000001 && !wr_left |=> !tone_active ##1 (!tone_active || $past(start));
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("Enable not cleared at end"); // RL1

	property p_idle_silent;
		@(posedge core_clk) disable iff (!rst_n)
		!tone_active && sample_tick |-> ##2 tone_left == 16'sh0000 && tone_right == 16'sh0000;
	endproperty
	a_idle_silent: assert property (p_idle_silent) else $error("Tone output while disabled"); // RL2

	property p_link_right;
		@(posedge core_clk) disable iff (!rst_n)
		raw_valid && link == 2'h1 && raw_sample[0] == raw_sample[1]
			|=> tone_left == tone_right;
	endproperty
	a_link_right: assert property (p_link_right) else $error("Left does not follow right gain"); // RL6

	property p_link_left;
		@(posedge core_clk) disable iff (!rst_n)
		link == 2'h2 |-> chan_code[1] == gain_l && chan_code[0] == gain_l;
	endproperty
	a_link_left: assert property (p_link_left) else $error("Right does not follow left gain"); // RL7

	property p_link_own;
		@(posedge core_clk) disable iff (!rst_n)
		link == 2'h0 || link == 2'h3 |-> chan_code[0] == gain_l && chan_code[1] == gain_r;
	endproperty
	a_link_own: assert property (p_link_own) else $error("Channel gains not independent"); // RL5

	property p_mode_hold;
		@(posedge core_clk) disable iff (!rst_n)
		tone_active && !tone_processing_mode && !reg_wr |=> $stable(remaining) && $stable(osc_y);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("Oscillator ran outside tone mode"); // RL11

	property p_count_down;
		@(posedge core_clk) disable iff (!rst_n)
		step && remaining > 24'h000001 && !wr_left |=> remaining == $past(remaining) - 24'h000001
			&& tone_active;
	endproperty
	a_count_down: assert property (p_count_down) else $error("Duration did not count down"); // RL13

	property p_len_write;
		@(posedge core_clk) disable iff (!rst_n)
		reg_wr && reg_addr == 7'h4b |=> len_cfg[7:0] == $past(reg_wdata);
	endproperty
	a_len_write: assert property (p_len_write) else $error("Length low byte not stored"); // RL8

	property p_sin_write;
		@(posedge core_clk) disable iff (!rst_n)
		reg_wr && reg_addr == 7'h4c |=> sin_coef[15:8] == $past(reg_wdata) ##1 reg_rdata != 8'hff
			|| reg_addr != 7'h4c || sin_hi == 8'hff;
	endproperty
	a_sin_write: assert property (p_sin_write) else $error("Sine high byte not stored"); // RL9

	property p_cos_write;
		@(posedge core_clk) disable iff (!rst_n)
		reg_wr && reg_addr == 7'h4f |=> cos_coef[7:0] == $past(reg_wdata);
	endproperty
	a_cos_write: assert property (p_cos_write) else $error("Cosine low byte not stored"); // RL10

endmodule

//--- test/btg_dac_sink.sv
module btg_dac_sink
(
	input wire logic core_clk,
	input wire logic run,
	input wire logic [2:0] spacing,
	input wire logic tone_valid,
	output logic sample_tick,
	output int n_ticks,
	output int n_samples
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] gap = 3'h7;
	initial
	begin
		sample_tick = 1'b0;
		n_ticks = 0;
		n_samples = 0;
	end
	// Word clock pulses, spacing idle cycles apart
	always @(negedge core_clk)
	begin
		sample_tick <= run && gap >= spacing;
		if (run && gap >= spacing)
		begin
			gap <= 3'h0;
			n_ticks <= n_ticks + 1;
		end
		else if (gap != 3'h7)
			gap <= gap + 3'h1;
	end
	always @(posedge core_clk)
	begin
		if (tone_valid)
			n_samples <= n_samples + 1;
	end
endmodule

//--- test/btg_top_tb.sv
module btg_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic tone_processing_mode = 1'b1;
	logic reg_wr = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic signed [15:0] tone_left;
	logic signed [15:0] tone_right;
	logic tone_valid;
	logic tone_active;
	logic sample_tick;
	logic run = 1'b0;
	logic [2:0] spacing = 3'h0;
	int n_ticks;
	int n_samples;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	logic look = 1'b0;
	logic look_d = 1'b0;
	logic [31:0] rd_q[$];
	logic [31:0] tn_q[$];
	logic [7:0] sh [0:8] = '{btg_pkg::BTG_RST_LEFT, btg_pkg::BTG_RST_RIGHT,
		btg_pkg::BTG_RST_LEN_HI, btg_pkg::BTG_RST_LEN_MID, btg_pkg::BTG_RST_LEN_LO,
		btg_pkg::BTG_RST_SIN_HI, btg_pkg::BTG_RST_SIN_LO, btg_pkg::BTG_RST_COS_HI,
		btg_pkg::BTG_RST_COS_LO};
	logic ref_act = 1'b0;
	logic [23:0] ref_cnt = 24'h0;
	logic signed [15:0] ox = 16'sh0;
	logic signed [15:0] oy = 16'sh0;
	longint sn;
	longint cs;
	int lk;
	int rk;
	wire [23:0] len = {sh[2], sh[3], sh[4]};

	always #5 core_clk = ~core_clk;

	btg_top i_btg_top
	(
		.core_clk(core_clk), .nrst(nrst), .sample_tick(sample_tick),
		.tone_processing_mode(tone_processing_mode), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.tone_left(tone_left), .tone_right(tone_right), .tone_valid(tone_valid),
		.tone_active(tone_active)
	);

	btg_dac_sink i_btg_dac_sink
	(
		.core_clk(core_clk), .run(run), .spacing(spacing), .tone_valid(tone_valid),
		.sample_tick(sample_tick), .n_ticks(n_ticks), .n_samples(n_samples)
	);

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want)
		begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ****************************************
	// Register and stream drivers
	// ****************************************
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
		if (a >= 7'h47 && a <= 7'h4f)
			sh[a - 7'h47] = d;
		if (a == btg_pkg::BTG_ADDR_LEFT)
		begin
			ref_act = d[7] && len != 24'h0;
			ref_cnt = len;
			ox = btg_pkg::BTG_OSC_INIT_X;
			oy = btg_pkg::BTG_OSC_INIT_Y;
		end
	endtask

	task automatic rd(input logic [6:0] a);
		@(negedge core_clk);
		reg_addr = a;
		look = 1'b1;
		if (a == btg_pkg::BTG_ADDR_LEFT)
			rd_q.push_back({24'h0, ref_act, sh[0][6:0]});
		else if (a > 7'h47 && a <= 7'h4f)
			rd_q.push_back({24'h0, sh[a - 7'h47]});
		else
			rd_q.push_back(32'h0);
		@(negedge core_clk);
		look = 1'b0;
	endtask

	task automatic play(input int n);
		int t0;
		@(negedge core_clk);
		t0 = n_ticks;
		spacing = 3'($urandom_range(0, 3));
		run = 1'b1;
		while (n_ticks < t0 + n)
			@(negedge core_clk);
		run = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask

	function automatic logic signed [15:0] sat(input longint v);
		if (v > 32767)
			return 16'sh7fff;
		if (v < -32768)
			return 16'sh8000;
		return v[15:0];
	endfunction

	// Gain code: mantissa of code mod 6, then one halving per 6 steps
	function automatic logic signed [15:0] amp(input logic signed [15:0] y, input int k);
		return sat((longint'(y) * longint'(btg_pkg::BTG_MANT[k % 6])) >>> (btg_pkg::BTG_GAIN_FRAC + k / 6));
	endfunction

	// ****************************************
	// Expected samples, one per word clock
	// ****************************************
	always @(posedge core_clk)
	begin
		look_d <= look;
		cycles <= cycles + 1;
		if (sample_tick)
		begin
			if (!(ref_act && tone_processing_mode))
				tn_q.push_back(32'h0);
			else
			begin
				lk = (sh[1][7:6] == 2'h1) ? sh[1][5:0] : sh[0][5:0];
				rk = (sh[1][7:6] == 2'h2) ? sh[0][5:0] : sh[1][5:0];
				tn_q.push_back({amp(oy, lk), amp(oy, rk)});
				sn = longint'($signed({sh[5], sh[6]}));
				cs = longint'($signed({sh[7], sh[8]}));
				{ox, oy} = {sat((cs * ox - sn * oy) >>> 15), sat((sn * ox + cs * oy) >>> 15)};
				ref_cnt = ref_cnt - 24'h1;
				if (ref_cnt == 24'h0)
					ref_act = 1'b0;
			end
		end
		if (cycles == 20000)
		begin
			fail_count++;
			test_done();
		end
	end

	always @(negedge core_clk)
	begin
		if (look_d)
		begin
			check({24'h0, reg_rdata}, rd_q.pop_front());
			check({31'h0, tone_active}, {31'h0, ref_act});
		end
		if (tone_valid)
			check({tone_left, tone_right}, tn_q.pop_front());
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		void'($urandom(32'h0bfc));
		repeat (8) @(negedge core_clk);
		nrst = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int a = 8'h47; a <= 8'h50; a++)
			rd(7'(a));
		// Default length and coefficients, random word clock spacing and idle tail
		wr(7'h48, 8'h02);
		wr(7'h47, 8'h82);
		play(250);
		rd(7'h47);
		// Stored bits read back with the tone held off
		for (int a = 8'h48; a <= 8'h4f; a++)
			wr(7'(a), 8'($urandom));
		wr(7'h47, {2'b00, 6'($urandom)});
		for (int a = 8'h47; a <= 8'h50; a++)
			rd(7'(a));
		wr(7'h49, 8'h00);
		wr(7'h4a, 8'h00);
		wr(7'h4b, 8'h14);
		for (int a = 8'h4c; a <= 8'h4f; a++)
			wr(7'(a), a[0] ? 8'h82 : 8'h5a);
		// Every link code, with a pause outside tone mode
		for (int m = 0; m < 4; m++)
		begin
			wr(7'h48, {2'(m), 6'($urandom)});
			wr(7'h47, {2'b10, 6'($urandom)});
			play(6);
			tone_processing_mode = 1'b0;
			play(3);
			tone_processing_mode = 1'b1;
			play(20);
			rd(7'h47);
		end
		// Stop mid tone, start, then restart while running
		wr(7'h47, 8'h82);
		play(4);
		wr(7'h47, 8'h02);
		play(3);
		wr(7'h47, 8'h82);
		play(3);
		rd(7'h47);
		wr(7'h47, 8'h82);
		play(25);
		// Length above one byte, then a zero length
		wr(7'h4a, 8'h01);
		wr(7'h4b, 8'h02);
		wr(7'h47, 8'h88);
		play(262);
		rd(7'h47);
		wr(7'h4a, 8'h00);
		wr(7'h4b, 8'h00);
		wr(7'h47, 8'h82);
		play(2);
		rd(7'h47);
		repeat (4) @(negedge core_clk);
		check(32'(n_samples), 32'(n_ticks));
		check(32'(tn_q.size()), 32'h0);
		test_done();
	end
endmodule
